// >>> design/nfs_host.v
// Host-side NAND flash sequencer: turns user operations into pin cycles.
// Assumes the device pins are wired to a flash model; the port is split
// into in/out/enable and resolved outside. Read data goes via a FIFO.
//
// Contract
// - Read is 00h, five address bytes, 30h.
// - Column change in read: 05h, column, E0h.
// - Multi read: 60h addr, 60h addr, 30h.
// - Hold write protect high during multi read.
// - At most four partial programs per page.
// - Program: 80h, address, data, then 10h.
// - Between 11h and 81h only 70h/FFh.
// - Multi program ends with 10h.
// - Multi erase: two 60h addresses, D0h.
// - Abandon erase setup with FFh reset.
// - Command with CLE, address with ALE.
// - Five cycles: two column, three row.
`timescale 1ns/1ps
`include "nfs_defs.vh"
module nfs_host (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // User request
  input wire req_valid,
  output reg req_ready,
  input wire [2:0] req_op,
  input wire [7:0] req_byte,
  input wire [12:0] req_col,
  input wire [16:0] req_row,
  input wire req_multi_rd,
  output reg req_err,
  // Read data out
  output reg rd_valid,
  input wire rd_ready,
  output reg [7:0] rd_data,
  // Flash pins
  output reg cle,
  output reg ale,
  output reg ce_n,
  output reg we_n,
  output reg output_strobe_n,
  output reg wp_n,
  input wire ready_busy_n,
  input wire [7:0] io_in,
  output reg [7:0] io_out,
  output reg io_oe
);
  localparam ST_IDLE = 3'h0;
  localparam ST_WLOW = 3'h1;
  localparam ST_WHIGH = 3'h2;
  localparam ST_RLOW = 3'h3;
  localparam ST_RHIGH = 3'h4;
  localparam ST_SETTLE = 3'h5;
  localparam ST_BUSY = 3'h6;
  reg [2:0] st_q;
  reg [1:0] ph_q;
  reg [2:0] left_q;
  reg [39:0] sh_q;
  reg [3:0] set_q;
  reg kind_cle_q;
  reg rb_s1_q;
  reg rb_s2_q;
  reg [7:0] io_s1_q;
  reg [7:0] io_s2_q;
  reg push_q;
  reg [7:0] push_d_q;
  reg multi_seen_q;
  reg kind_ale_q;
  wire fifo_rdy;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire fifo_take;
  wire [39:0] addr5;
  wire bad_col;
  wire phase_end;
  // Five address bytes, column then row, unused high bits low
  assign addr5 = {7'h00, req_row, 3'h0, req_col};
  // Parity columns and above are never addressed by this host
  assign bad_col = (req_col >= `NFS_COL_PARITY);
  assign phase_end = (ph_q == `NFS_PHASE_CYC - 2'h1);
  // Pin inputs pass two flops before use
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
      io_s1_q <= 8'h00;
      io_s2_q <= 8'h00;
    end else begin
      rb_s1_q <= ready_busy_n;
      rb_s2_q <= rb_s1_q;
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
    end
  end
  // Read FIFO; stalls the sequencer when full
  nfs_fifo #(.WIDTH(8), .DEPTH(4), .AW(2)) u_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .in_valid(push_q),
    .in_ready(fifo_rdy),
    .in_data(push_d_q),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_take),
    .out_data(fifo_out_data)
  );
  // Output stage keeps the user outputs on flops; adds one word of slack
  assign fifo_take = !rd_valid || rd_ready;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end else if (fifo_take) begin
      rd_valid <= fifo_out_valid;
      rd_data <= fifo_out_data;
    end
  end
  // Main sequencer
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      ph_q <= 2'h0;
      left_q <= 3'h0;
      sh_q <= 40'h0;
      set_q <= 4'h0;
      kind_cle_q <= 1'b0;
      kind_ale_q <= 1'b0;
      push_q <= 1'b0;
      push_d_q <= 8'h00;
      multi_seen_q <= 1'b0;
      req_ready <= 1'b0;
      req_err <= 1'b0;
      cle <= 1'b0;
      ale <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      output_strobe_n <= 1'b1;
      wp_n <= 1'b0;
      io_out <= 8'h00;
      io_oe <= 1'b0;
    end else begin
      push_q <= 1'b0;
      req_err <= 1'b0;
      wp_n <= 1'b1;
      ce_n <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          // A push still in flight may be the one that fills the FIFO
          req_ready <= fifo_rdy & ~push_q;
          cle <= 1'b0;
          ale <= 1'b0;
          io_oe <= 1'b0;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            ph_q <= 2'h0;
            kind_cle_q <= (req_op == `NFS_OP_CMD);
            kind_ale_q <= (req_op == `NFS_OP_ADDR5) ||
              (req_op == `NFS_OP_ADDR2) || (req_op == `NFS_OP_ADDR3);
            case (req_op)
              `NFS_OP_CMD: begin
                // ECC status refused after a multi-page read
                if (req_byte == `NFS_CMD_ECC && multi_seen_q) begin
                  req_err <= 1'b1;
                  st_q <= ST_IDLE;
                end else begin
                  sh_q <= {32'h0, req_byte};
                  left_q <= 3'h1;
                  st_q <= ST_WLOW;
                  if (req_byte == `NFS_CMD_READ_GO) begin
                    multi_seen_q <= req_multi_rd;
                  end
                end
              end
              `NFS_OP_ADDR5, `NFS_OP_ADDR2: begin
                if (bad_col) begin
                  req_err <= 1'b1;
                end else begin
                  sh_q <= addr5;
                  left_q <= (req_op == `NFS_OP_ADDR5) ? 3'h5 : 3'h2;
                  st_q <= ST_WLOW;
                end
              end
              `NFS_OP_ADDR3: begin
                // Erase block address is the row only
                sh_q <= {16'h0, 7'h00, req_row};
                left_q <= 3'h3;
                st_q <= ST_WLOW;
              end
              `NFS_OP_WDATA: begin
                sh_q <= {32'h0, req_byte};
                left_q <= 3'h1;
                st_q <= ST_WLOW;
              end
              `NFS_OP_RDATA: begin
                st_q <= ST_RLOW;
              end
              `NFS_OP_WAIT: begin
                set_q <= 4'h0;
                st_q <= ST_SETTLE;
              end
              default: begin
                req_err <= 1'b1;
              end
            endcase
          end
        end
        ST_WLOW: begin
          // Byte set up with strobe low; latch on rising edge
          cle <= kind_cle_q;
          ale <= kind_ale_q; // Data bytes go with both latches low
          io_out <= sh_q[7:0];
          io_oe <= 1'b1;
          we_n <= 1'b0;
          ph_q <= ph_q + 2'h1;
          if (phase_end) begin
            ph_q <= 2'h0;
            st_q <= ST_WHIGH;
          end
        end
        ST_WHIGH: begin
          we_n <= 1'b1;
          ph_q <= ph_q + 2'h1;
          if (phase_end) begin
            ph_q <= 2'h0;
            sh_q <= {8'h00, sh_q[39:8]};
            left_q <= left_q - 3'h1;
            st_q <= (left_q == 3'h1) ? ST_IDLE : ST_WLOW;
          end
        end
        ST_RLOW: begin
          io_oe <= 1'b0;
          output_strobe_n <= 1'b0;
          ph_q <= ph_q + 2'h1;
          if (phase_end) begin
            ph_q <= 2'h0;
            st_q <= ST_RHIGH;
          end
        end
        ST_RHIGH: begin
          // Sample after sync delay, at the end of the high phase
          output_strobe_n <= 1'b1;
          ph_q <= ph_q + 2'h1;
          if (phase_end) begin
            ph_q <= 2'h0;
            push_q <= 1'b1;
            push_d_q <= io_s2_q;
            st_q <= ST_IDLE;
          end
        end
        ST_SETTLE: begin
          // Busy may take a while to fall after the last strobe
          set_q <= set_q + 4'h1;
          if (set_q == `NFS_RB_SETTLE) begin
            st_q <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (rb_s2_q) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> design/nfs_defs.vh
// Constants for the NAND flash host sequencer.
// Assumes an 8-bit shared port and a 40 MHz mclk.
`ifndef NFS_DEFS_VH
`define NFS_DEFS_VH
// ----------------------------------------------------------------
// Commands
// ----------------------------------------------------------------
`define NFS_CMD_READ 8'h00
`define NFS_CMD_READ_GO 8'h30
`define NFS_CMD_RCOL 8'h05
`define NFS_CMD_RCOL_GO 8'he0
`define NFS_CMD_MREAD 8'h60
`define NFS_CMD_PROG 8'h80
`define NFS_CMD_PROG2 8'h81
`define NFS_CMD_WCOL 8'h85
`define NFS_CMD_PROG_GO 8'h10
`define NFS_CMD_PROG_MID 8'h11
`define NFS_CMD_ERASE 8'h60
`define NFS_CMD_ERASE_GO 8'hd0
`define NFS_CMD_STATUS 8'h70
`define NFS_CMD_STATUS2 8'h71
`define NFS_CMD_ECC 8'h7a
`define NFS_CMD_RESET 8'hff
// ----------------------------------------------------------------
// User operation codes
// ----------------------------------------------------------------
`define NFS_OP_CMD 3'h0
`define NFS_OP_ADDR5 3'h1
`define NFS_OP_ADDR2 3'h2
`define NFS_OP_ADDR3 3'h3
`define NFS_OP_WDATA 3'h4
`define NFS_OP_RDATA 3'h5
`define NFS_OP_WAIT 3'h6
// ----------------------------------------------------------------
// Address layout and limits
// ----------------------------------------------------------------
`define NFS_COL_W 13
`define NFS_ROW_W 17
`define NFS_COL_PARITY 13'h1080
`define NFS_DIST_BIT 6
// ----------------------------------------------------------------
// Timing: strobe phase length in mclk cycles (25 ns each)
// ----------------------------------------------------------------
`define NFS_T_PHASE_NS 25
`define NFS_CLK_MHZ 40
`define NFS_PHASE_CYC 2'h2
`define NFS_RB_SETTLE 4'h8
`endif

// >>> design/nfs_fifo.v
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock, mclk, and active-low async reset rstn.
`timescale 1ns/1ps
module nfs_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  // Honest full and empty from the occupancy count
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // Storage write; no reset needed on data words
  always @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  // Pointers and count
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// >>> tb/nfs_flash_model.sv
// Behavioural flash device on the host pins.
// Assumes the bench resolves the shared port.
`timescale 1ns/1ps
module nfs_flash_model #(
  parameter BUSY_NS = 2000,
  parameter HOLD_NS = 50
) (
  // Strobes and port from the host
  input wire cle,
  input wire ale,
  input wire ce_n,
  input wire we_n,
  input wire output_strobe_n,
  input wire wp_n,
  input wire [7:0] io,
  // Back to the host
  output reg [7:0] dq,
  output reg ready_busy_n
);
  reg [7:0] cmd_q = 8'h00;
  reg [12:0] col_q = 13'h0000;
  integer n = 0;
  initial dq = 8'h00;
  initial ready_busy_n = 1'b1;
  // Latch on rising write strobe; array work goes busy
  always @(posedge we_n) if (!ce_n && cle) begin
    cmd_q = io;
    n = 0;
    if (io == 8'h30 || io == 8'h10 || io == 8'hd0) begin
      ready_busy_n = 1'b0;
      ready_busy_n <= #BUSY_NS 1'b1;
    end
  end else if (!ce_n && ale) begin
    if (n == 0) col_q[7:0] = io;
    if (n == 1) col_q[12:8] = io[4:0];
    n = n + 1;
  end
  // Status after 70h or 71h, else bytes from the column
  always @(negedge output_strobe_n) if (!ce_n) begin
    // Always pass: no ECC failure and no program fault is modelled
    if (cmd_q == 8'h70 || cmd_q == 8'h71)
      dq = {wp_n, 7'h60};
    else begin
      dq = col_q[7:0];
      col_q = col_q + 13'h0001;
    end
  end
  // Released port does not keep the old byte
  always @(posedge output_strobe_n) dq <= #HOLD_NS ~dq;
endmodule

// >>> tb/nfs_host_assertions.sv
// Pin-level properties of the host sequencer.
// Assumes a bind onto nfs_host ports.
`timescale 1ns/1ps
module nfs_host_chk (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // User side
  input wire req_valid,
  input wire req_ready,
  input wire [2:0] req_op,
  input wire [7:0] req_byte,
  input wire req_err,
  // Pins
  input wire cle,
  input wire ale,
  input wire we_n,
  input wire output_strobe_n,
  input wire wp_n,
  input wire ready_busy_n,
  input wire [7:0] io_out,
  input wire io_oe
);
  reg [7:0] byte_q;
  // Last byte taken, compared later with the port
  always @(posedge mclk or negedge rstn)
    if (!rstn) byte_q <= 8'h00;
    else if (req_valid && req_ready) byte_q <= req_byte;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_wp_high; $past(rstn) |-> wp_n; endproperty
  a_wp_high: assert property (p_wp_high) else $error("wp low");
  property p_cmd_pins; cle |-> !ale && io_oe && output_strobe_n; endproperty
  a_cmd_pins: assert property (p_cmd_pins) else $error("cmd pins");
  property p_addr_pins; ale |-> !cle && io_oe && output_strobe_n; endproperty
  a_addr_pins: assert property (p_addr_pins) else $error("addr");
  property p_rd_pins; !output_strobe_n |-> !io_oe && !cle && !ale && we_n;
  endproperty
  a_rd_pins: assert property (p_rd_pins) else $error("read pins");
  property p_we_pulse; $fell(we_n) |=> !we_n ##1 we_n; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("we width");
  property p_busy; !ready_busy_n |-> we_n && output_strobe_n; endproperty
  a_busy: assert property (p_busy) else $error("strobe in busy");
  property p_refuse; req_err |-> we_n ##1 !req_err && we_n; endproperty
  a_refuse: assert property (p_refuse) else $error("refusal");
  property p_cmd_issue; req_valid && req_ready && req_op == 3'h0 &&
    req_byte != 8'h7a |-> ##[1:3] (cle && !we_n && io_out == byte_q);
  endproperty
  a_cmd_issue: assert property (p_cmd_issue) else $error("cmd");
  property p_data_pins; req_valid && req_ready && req_op == 3'h4 |->
    ##2 (!cle && !ale && !we_n && io_oe && wp_n && io_out == byte_q);
  endproperty
  a_data_pins: assert property (p_data_pins) else $error("data");
endmodule

// >>> tb/nfs_host_tb.sv
// Self-checking bench: host sequencer against a flash model.
// Assumes design, model and checker compiled before it.
`timescale 1ns/1ps
module nfs_host_tb;
  reg mclk = 1'b0;
  reg rstn = 1'b0;
  reg req_valid = 1'b0;
  reg [2:0] req_op = 3'h0;
  reg [7:0] req_byte = 8'h00;
  reg [12:0] req_col = 13'h0000;
  reg [16:0] req_row = 17'h00000;
  reg req_multi_rd = 1'b0;
  reg rd_ready = 1'b0;
  reg stall = 1'b0;
  reg [7:0] exp_q[$];
  reg [12:0] col;
  integer bad_count = 0, checks_done = 0, cyc = 0, errs = 0, i;
  wire req_ready, req_err, rd_valid, cle, ale, ce_n, we_n, io_oe;
  wire output_strobe_n, wp_n, ready_busy_n;
  wire [7:0] rd_data, io_out, dq;
  wire [7:0] io_in = io_oe ? io_out : dq;
  nfs_host nfs_host_inst (.mclk(mclk), .rstn(rstn),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_byte(req_byte), .req_col(req_col), .req_row(req_row),
    .req_multi_rd(req_multi_rd), .req_err(req_err), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .cle(cle), .ale(ale),
    .ce_n(ce_n), .we_n(we_n), .output_strobe_n(output_strobe_n),
    .wp_n(wp_n), .ready_busy_n(ready_busy_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe));
  nfs_flash_model nfs_flash_model_inst (.cle(cle), .ale(ale),
    .ce_n(ce_n), .we_n(we_n), .output_strobe_n(output_strobe_n),
    .wp_n(wp_n), .io(io_in), .dq(dq), .ready_busy_n(ready_busy_n));
  initial forever #12.5 mclk = ~mclk;
  task chk(input [7:0] seen, input [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hold the request until the edge that takes it
  task req(input [2:0] op, input [7:0] b, input [12:0] c,
    input [16:0] r, input m);
    integer k;
    k = 0;
    @(posedge mclk);
    req_op <= op;
    req_byte <= b;
    req_col <= c;
    req_row <= r;
    req_multi_rd <= m;
    req_valid <= 1'b1;
    @(posedge mclk);
    while (req_ready !== 1'b1 && k < 500) begin
      @(posedge mclk);
      k = k + 1;
    end
    if (k == 500) bad_count = bad_count + 1;
    req_valid <= 1'b0;
  endtask
  task cmd(input [7:0] b);
    req(3'h0, b, 13'h0000, 17'h00000, 1'b0);
  endtask
  task rd(input [7:0] e);
    exp_q.push_back(e);
    req(3'h5, 8'h00, 13'h0000, 17'h00000, 1'b0);
  endtask
  // Watcher: pops the oldest note per byte; random drain stalls
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      conclude;
    end
    if (req_err === 1'b1) errs = errs + 1;
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      chk(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    rd_ready <= !stall && ($urandom % 3 != 0);
  end
  initial begin
    void'($urandom(89958));
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    col = $urandom % 4000;
    // Read after power-up with no 00h; fill the buffer
    req(3'h1, 8'h00, col, 17'h00145, 1'b0);
    cmd(8'h30);
    req(3'h6, 8'h00, 13'h0000, 17'h00000, 1'b0);
    stall <= 1'b1;
    // Four FIFO words plus the output stage hold five bytes
    for (i = 0; i < 5; i = i + 1) rd(col[7:0] + i);
    repeat (12) @(posedge mclk);
    chk({7'h00, req_ready}, 8'h00);
    stall <= 1'b0;
    // Column change, wrap of the low byte, then parity refused
    cmd(8'h05);
    req(3'h2, 8'h00, 13'h00ff, 17'h00000, 1'b0);
    cmd(8'he0);
    rd(8'hff);
    rd(8'h00);
    cmd(8'h05);
    req(3'h2, 8'h00, 13'h1080, 17'h00000, 1'b0);
    req(3'h2, 8'h00, 13'h107f, 17'h00000, 1'b0);
    cmd(8'he0);
    rd(8'h7f);
    cmd(8'h70);
    rd(8'he0);
    // Program with a column move
    cmd(8'h80);
    req(3'h1, 8'h00, 13'h0200, 17'h00240, 1'b0);
    req(3'h4, $urandom, 13'h0000, 17'h00000, 1'b0);
    cmd(8'h85);
    req(3'h2, 8'h00, 13'h1010, 17'h00000, 1'b0);
    req(3'h4, $urandom, 13'h0000, 17'h00000, 1'b0);
    cmd(8'h10);
    req(3'h6, 8'h00, 13'h0000, 17'h00000, 1'b0);
    cmd(8'h70);
    rd(8'he0);
    // Two-district erase, odd block first
    cmd(8'h60);
    req(3'h3, 8'h00, 13'h0000, 17'h00240, 1'b0);
    cmd(8'h60);
    req(3'h3, 8'h00, 13'h0000, 17'h00080, 1'b0);
    cmd(8'hd0);
    req(3'h6, 8'h00, 13'h0000, 17'h00000, 1'b0);
    cmd(8'h71);
    rd(8'he0);
    // Multi read refuses ECC status; single read allows it
    cmd(8'h60);
    req(3'h1, 8'h00, 13'h0000, 17'h00105, 1'b0);
    cmd(8'h60);
    req(3'h1, 8'h00, 13'h0000, 17'h001c5, 1'b0);
    req(3'h0, 8'h30, 13'h0000, 17'h00000, 1'b1);
    req(3'h6, 8'h00, 13'h0000, 17'h00000, 1'b0);
    cmd(8'h7a);
    cmd(8'h00);
    req(3'h1, 8'h00, 13'h0000, 17'h00105, 1'b0);
    cmd(8'h30);
    req(3'h6, 8'h00, 13'h0000, 17'h00000, 1'b0);
    cmd(8'h7a);
    repeat (4) @(posedge mclk);
    while (exp_q.size() > 0) @(posedge mclk);
    chk(errs, 8'h02);
    conclude;
  end
endmodule
bind nfs_host nfs_host_chk nfs_host_chk_inst (.mclk(mclk), .rstn(rstn),
  .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
  .req_byte(req_byte), .req_err(req_err), .cle(cle), .ale(ale),
  .we_n(we_n), .output_strobe_n(output_strobe_n), .wp_n(wp_n),
  .ready_busy_n(ready_busy_n), .io_out(io_out), .io_oe(io_oe));
